// ==== vga_ctrl_cfg.svh ====
`ifndef VGA_CTRL_CFG_SVH
`define VGA_CTRL_CFG_SVH

// control word geometry and power-on value
`define WORD_BITS      16
`define WORD_RESET     16'h000a
`define POWER_BIT      10
`define FILTER_MSB     8
`define FILTER_LSB     6
`define PREAMP_BIT     4
`define LADDER_MSB     3
`define LADDER_LSB     0
// frame length: one read/write bit then the word
`define FRAME_BITS     17
`define CNT_BITS       5

`endif

// ==== vga_ctrl_pkg.sv ====
package vga_ctrl_pkg;
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_data = 3'b010,
		st_done = 3'b100
	} frame_state_t;

	typedef enum logic [2:0] {
		bw_full = 3'h0,
		bw_20   = 3'h1,
		bw_100  = 3'h2,
		bw_200  = 3'h3,
		bw_350  = 3'h4,
		bw_650  = 3'h5,
		bw_750  = 3'h6
	} filter_sel_t;
endpackage

// ==== pin_sync_if.sv ====
// synchronised select and data levels and qualified clock edges
interface pin_sync_if;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_act;
	logic sdio_lvl;
	modport src (output sclk_rise, output sclk_fall, output sel_act,
		output sdio_lvl);
	modport dst (input sclk_rise, input sclk_fall, input sel_act,
		input sdio_lvl);
endinterface

// ==== pin_sync.sv ====
// three-stage sampling of the serial pins; a change counts when
// stages two and three agree
module pin_sync (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	input  wire logic sdio_i,
	pin_sync_if.src   pins
);
	logic [2:0] sclk_sr;
	logic [2:0] cs_sr;
	logic [2:0] sdio_sr;
	logic       sclk_lvl;

	// shift registers
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sclk_sr <= 3'h0;
			cs_sr   <= 3'h7;
			sdio_sr <= 3'h0;
		end else begin
			sclk_sr <= {sclk_sr[1:0], sclk_i};
			cs_sr   <= {cs_sr[1:0], cs_n_i};
			sdio_sr <= {sdio_sr[1:0], sdio_i};
		end
	end

	// accepted levels, updated only on agreement
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sclk_lvl      <= 1'b0;
			pins.sel_act  <= 1'b0;
			pins.sdio_lvl <= 1'b0;
		end else begin
			if (sclk_sr[1] == sclk_sr[2])
				sclk_lvl <= sclk_sr[2];
			if (cs_sr[1] == cs_sr[2])
				pins.sel_act <= ~cs_sr[2];
			if (sdio_sr[1] == sdio_sr[2])
				pins.sdio_lvl <= sdio_sr[2];
		end
	end

	// edge pulses of the accepted clock level
	assign pins.sclk_rise = ~sclk_lvl & sclk_sr[1] & sclk_sr[2];
	assign pins.sclk_fall = sclk_lvl & ~sclk_sr[1] & ~sclk_sr[2];
endmodule

// ==== vga_serial_control.sv ====
`include "vga_ctrl_cfg.svh"
// Summary of operation
// - host writes and reads back the control word
// - one two-way data pin carries both directions
// - host clocks; device answers only while selected
// - bit 10 high puts auxiliary output Hi-Z
// - bits 8..6 choose the bandwidth limit
// - one filter setting feeds both outputs
// - bit 4 chooses preamp high or low gain
// - bits 3..0 set ladder in 2 dB steps
// - reset word 000a: full bw, low gain, 20 dB
// - high gain 30 dB, low gain 10 dB
module vga_serial_control (
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       sclk_i,
	input  wire logic       cs_n_i,
	input  wire logic       sdio_i,
	output logic            sdio_o,
	output logic            sdio_oe_n_o,
	output logic            aux_hiz_o,
	output logic [2:0]      filter_sel_o,
	output logic            preamp_high_gain_o,
	output logic            preamp_low_gain_o,
	output logic [3:0]      ladder_atten_o,
	output logic [15:0]     control_word_o
);
	pin_sync_if pins ();

	pin_sync u_sync (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.sclk_i     (sclk_i),
		.cs_n_i     (cs_n_i),
		.sdio_i     (sdio_i),
		.pins       (pins)
	);

	vga_ctrl_pkg::frame_state_t state;
	logic [`CNT_BITS-1:0]       bit_cnt;
	logic                       is_read;
	logic [`WORD_BITS-1:0]      shift_in;
	logic [`WORD_BITS-1:0]      shift_out;
	logic [`WORD_BITS-1:0]      gain_filter_control_word;
	logic                       word_done;

	// final rising edge of a write frame completes the word
	assign word_done = (state == vga_ctrl_pkg::st_data) && pins.sclk_rise
		&& (bit_cnt == 5'(`FRAME_BITS - 1));

	// frame sequencer: first rising edge holds read/write flag
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state   <= vga_ctrl_pkg::st_idle;
			bit_cnt <= 5'h0;
			is_read <= 1'b0;
		end else if (!pins.sel_act) begin
			state   <= vga_ctrl_pkg::st_idle;
			bit_cnt <= 5'h0;
		end else begin
			case (state)
				vga_ctrl_pkg::st_idle: begin
					if (pins.sclk_rise) begin
						is_read <= pins.sdio_lvl;
						bit_cnt <= 5'h1;
						state   <= vga_ctrl_pkg::st_data;
					end
				end
				vga_ctrl_pkg::st_data: begin
					if (pins.sclk_rise) begin
						bit_cnt <= bit_cnt + 5'h1;
						if (bit_cnt == 5'(`FRAME_BITS - 1))
							state <= vga_ctrl_pkg::st_done;
					end
				end
				vga_ctrl_pkg::st_done: begin
					state <= vga_ctrl_pkg::st_done; // wait for deselect
				end
				default: begin
					state <= vga_ctrl_pkg::st_idle;
				end
			endcase
		end
	end

	// capture write data on rising edges, MSB first
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			shift_in <= 16'h0000;
		else if (state == vga_ctrl_pkg::st_data && pins.sclk_rise)
			shift_in <= {shift_in[14:0], pins.sdio_lvl};
	end

	// control word: power-on default, loaded at end of a write
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			gain_filter_control_word <= `WORD_RESET;
		else if (word_done && !is_read)
			gain_filter_control_word <= {shift_in[14:0], pins.sdio_lvl};
	end

	// read path: load word after flag, shift on falling edges
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			shift_out   <= 16'h0000;
			sdio_o      <= 1'b0;
			sdio_oe_n_o <= 1'b1;
		end else if (!pins.sel_act) begin
			sdio_oe_n_o <= 1'b1;
			sdio_o      <= 1'b0;
		end else if (state == vga_ctrl_pkg::st_idle && pins.sclk_rise
			&& pins.sdio_lvl) begin
			shift_out <= gain_filter_control_word;
		end else if (state == vga_ctrl_pkg::st_data && is_read
			&& pins.sclk_fall) begin
			sdio_o      <= shift_out[15];
			sdio_oe_n_o <= 1'b0;
			shift_out   <= {shift_out[14:0], 1'b0};
		end else if (state == vga_ctrl_pkg::st_done && pins.sclk_fall) begin
			sdio_oe_n_o <= 1'b1;
		end
	end

	// decoded analog controls, all registered
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			aux_hiz_o          <= 1'b0;
			filter_sel_o       <= 3'h0;
			preamp_high_gain_o <= 1'b0;
			preamp_low_gain_o  <= 1'b1;
			ladder_atten_o     <= 4'ha;
			control_word_o     <= `WORD_RESET;
		end else begin
			aux_hiz_o <= gain_filter_control_word[`POWER_BIT];
			// one selection for main and aux outputs
			filter_sel_o <= gain_filter_control_word
				[`FILTER_MSB:`FILTER_LSB];
			// high 30 dB stage vs low 10 dB stage
			preamp_high_gain_o <= gain_filter_control_word
				[`PREAMP_BIT];
			preamp_low_gain_o <= ~gain_filter_control_word
				[`PREAMP_BIT];
			ladder_atten_o <= gain_filter_control_word
				[`LADDER_MSB:`LADDER_LSB];
			control_word_o <= gain_filter_control_word;
		end
	end
endmodule

// ==== vga_serial_control_monitor.sv ====
module vga_serial_control_monitor (
	input wire logic        core_clk_i,
	input wire logic        rst_n_i,
	input wire logic        cs_n_i,
	input wire logic        sdio_oe_n_o,
	input wire logic        aux_hiz_o,
	input wire logic [2:0]  filter_sel_o,
	input wire logic        preamp_high_gain_o,
	input wire logic        preamp_low_gain_o,
	input wire logic [3:0]  ladder_atten_o,
	input wire logic [15:0] control_word_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// decoded outputs and the word copy load from one register together
	aux_follow_a: assert property (
		aux_hiz_o == control_word_o[10]) else $error("aux");
	filter_follow_a: assert property (
		filter_sel_o == control_word_o[8:6]) else $error("filter");
	gain_follow_a: assert property (
		preamp_high_gain_o == control_word_o[4]) else $error("gain");
	gain_pair_a: assert property (
		preamp_low_gain_o != preamp_high_gain_o) else $error("gain pair");
	ladder_follow_a: assert property (
		ladder_atten_o == control_word_o[3:0]) else $error("ladder");
	reset_word_a: assert property (
		$rose(rst_n_i) |-> control_word_o == 16'h000a) else $error("reset");
	drive_release_a: assert property (
		$rose(cs_n_i) |-> ##[1:8] sdio_oe_n_o) else $error("release");
	idle_hold_a: assert property (
		cs_n_i && $past(cs_n_i, 8) |-> $stable(control_word_o))
		else $error("idle");
	// main scenarios seen
	cover property ($fell(sdio_oe_n_o));
	cover property ($changed(control_word_o));
	cover property ($rose(aux_hiz_o));
endmodule

// ==== spi_host_model.sv ====
module spi_host_model (
	output logic     sclk_o,
	output logic     cs_n_o,
	output logic     sdio_o,
	output logic     sdio_en_o,
	input wire logic sdio_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// bus idles deselected, clock low
	initial begin
		{sclk_o, cs_n_o, sdio_o, sdio_en_o} = 4'h5;
	end
	// direction bit then n bits msb first; sample on rising edge
	task automatic xfer(input logic rd, input logic [15:0] w,
		input int n, output logic [15:0] r);
		r = 16'h0000;
		cs_n_o = 0;
		for (int i = 0; i <= n; i++) begin
			sdio_o = (i == 0) ? rd : w[16 - i];
			sdio_en_o = (i == 0) || !rd;
			#62.5 sclk_o = 1;
			r = {r[14:0], sdio_i};
			#62.5 sclk_o = 0;
		end
		#62.5 {cs_n_o, sdio_en_o} = 2'h3;
		#400;
	endtask
endmodule

// ==== vga_serial_control_bench.sv ====
module vga_serial_control_bench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [15:0] w;
		logic [8:0]  d;
	} row_t;
	// rows keep reserved bits zero and codes allowed
	row_t        rows [7] = '{{16'h0000, 9'h000}, {16'h0451, 9'h131},
		{16'h0082, 9'h042}, {16'h04d3, 9'h173}, {16'h0104, 9'h084},
		{16'h0555, 9'h1b5}, {16'h018a, 9'h0ca}};
	logic        clk = 0;
	logic        rst_n = 0;
	logic        sclk, cs_n, hd, hen, dsd, oe_n, aux, hg, lg;
	logic [2:0]  filt;
	logic [3:0]  lad;
	logic [15:0] word, rd;
	int          fails = 0;
	int          num_checks = 0;
	int          cyc = 0;
	wire [8:0]   dec = {aux, filt, hg, lad};
	// undriven pin shows the inverted device output dsd
	wire         pin = !oe_n ? dsd : hen ? hd : ~dsd;
	always #4 clk = ~clk;
	vga_serial_control DUT (.core_clk_i(clk), .rst_n_i(rst_n),
		.sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(pin), .sdio_o(dsd),
		.sdio_oe_n_o(oe_n), .aux_hiz_o(aux), .filter_sel_o(filt),
		.preamp_high_gain_o(hg), .preamp_low_gain_o(lg),
		.ladder_atten_o(lad), .control_word_o(word));
	spi_host_model h (.sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(hd),
		.sdio_en_o(hen), .sdio_i(pin));
	task automatic chk(input string s, input logic [15:0] e, g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end
	// write each row, check decode, read it back
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1;
		repeat (4) @(negedge clk);
		chk("reset", 16'h000a, word);
		chk("low", 16'h0001, 16'(lg));
		foreach (rows[i]) begin
			h.xfer(0, rows[i].w, 16, rd);
			chk("dec", 16'(rows[i].d), 16'(dec));
			chk("lg", 16'(!rows[i].d[4]), 16'(lg));
			h.xfer(1, 16'h0000, 16, rd);
			chk("read", rows[i].w, rd);
		end
		h.xfer(0, 16'h0000, 9, rd);
		chk("abort", 16'h018a, word);
		chk("oe", 16'h0001, 16'(oe_n));
		rst_n = 0;
		repeat (2) @(negedge clk);
		rst_n = 1;
		@(negedge clk);
		chk("rst2", 16'h000a, word);
		chk("rst2 lad", 16'h000a, 16'(lad));
		end_of_test();
	end
endmodule
bind vga_serial_control vga_serial_control_monitor mon (.*);
